/* hw/ssei_pkg.sv */
// Shared constants, codes and types for the safe torque off status and error indicator
package ssei_pkg;

    // ------------------------------------------------------------
    // Lamp colour codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SSEI_LAMP_OFF    = 2'h0,
        SSEI_LAMP_GREEN  = 2'h1,
        SSEI_LAMP_YELLOW = 2'h2
    } ssei_lamp_t;

    // ------------------------------------------------------------
    // Display characters (symbol codes for the seven-segment driver)
    // ------------------------------------------------------------
    localparam logic [4:0] SSEI_CH_BLANK  = 5'h10;
    localparam logic [4:0] SSEI_CH_E      = 5'h0e;
    localparam logic [4:0] SSEI_CH_H      = 5'h11;
    localparam logic [4:0] SSEI_CH_HYPHEN = 5'h12;

    // ------------------------------------------------------------
    // Error codes, main index and sub-index as decimal digits
    // ------------------------------------------------------------
    localparam logic [11:0] SSEI_ERR_51_0 = 12'h510;
    localparam logic [11:0] SSEI_ERR_51_2 = 12'h512;
    localparam logic [11:0] SSEI_ERR_51_3 = 12'h513;
    localparam logic [11:0] SSEI_ERR_52_1 = 12'h521;
    localparam logic [11:0] SSEI_ERR_52_2 = 12'h522;
    localparam int          SSEI_NUM_ERR  = 5;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SSEI_CLK_HZ         = 25000000;
    localparam int SSEI_DISC_TIME_MS   = 10;
    localparam int SSEI_DISC_CYCLES    = SSEI_DISC_TIME_MS * (SSEI_CLK_HZ / 1000);
    localparam int SSEI_SYM_TIME_MS    = 500;
    localparam int SSEI_SYM_CYCLES     = SSEI_SYM_TIME_MS * (SSEI_CLK_HZ / 1000);
    localparam int SSEI_MSG_LEN        = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [SSEI_NUM_ERR-1:0] SSEI_ERR_RST = '0;

endpackage

/* hw/ssei_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous input levels
`timescale 1ns/1ps
module ssei_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    initial
    begin
        if (WIDTH < 1)
        begin
            $error("ssei_sync: WIDTH must be at least 1");
        end
    end

    // ------------------------------------------------------------
    // Two flip-flops; only the second stage is read outside
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            meta_r   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

/* hw/ssei_top.sv */
// Safe torque off status lamp, feedback contact and error display sequencer
//
// Operation
// - Lamp yellow while safe torque off is active.
// - Lamp green while safe torque off is inactive, stage state irrelevant.
// - Lamp dark when module or drive lacks operating voltage.
// - Display shows H while drive is in its safe status and no error stands.
// - No unsafe-status glyph; normal drive display passes through.
// - Error shown cyclically as E, main index, sub-index.
// - Warning shows same code framed by hyphens, not E.
// - Error 51-0: module absent, unknown, or internal voltage fault.
// - Error 51-2: module type/version differs from design until accepted.
// - Error 51-3: module type or version unsupported.
// - Error 52-1: channels not switched together within discrepancy time.
// - Error 52-2: safe state requested with stage still modulating.
// - Non-acknowledgeable errors persist until reset (51-2 until accepted), then recheck cause.
// - Feedback contact pair reports safe torque off state.
// - Module change raises non-acknowledgeable error until accepted.
`timescale 1ns/1ps
module ssei_top
    import ssei_pkg::*;
#(
    parameter int DISC_CYCLES = SSEI_DISC_CYCLES,
    parameter int SYM_CYCLES  = SSEI_SYM_CYCLES
) (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       torque_off_input_a,
    input  wire logic       torque_off_input_b,
    input  wire logic       module_power_ok,
    input  wire logic       drive_power_ok,
    input  wire logic       module_present,
    input  wire logic       module_type_known,
    input  wire logic       module_voltage_fault,
    input  wire logic       module_matches_design,
    input  wire logic       module_change_accept,
    input  wire logic       module_supported,
    input  wire logic       stage_modulating,
    input  wire logic       drive_safe_status,
    input  wire logic       warning_mode,
    input  wire logic       error_ack,
    input  wire logic [4:0] normal_symbol,
    output logic [1:0]      lamp_colour,
    output logic            state_feedback_contact_1,
    output logic            state_feedback_contact_2,
    output logic [4:0]      display_symbol,
    output logic [4:0]      error_active,
    output logic            sto_active
);

    localparam int CW = 32;

    initial
    begin
        if (DISC_CYCLES < 1 || SYM_CYCLES < 1)
        begin
            $error("ssei_top: cycle counts must be at least 1");
        end
    end

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    logic [13:0] pins_s;
    logic        in_a_s;
    logic        in_b_s;
    logic        mod_pwr_s;
    logic        drv_pwr_s;
    logic        present_s;
    logic        known_s;
    logic        vfault_s;
    logic        match_s;
    logic        accept_s;
    logic        supp_s;
    logic        pwm_s;
    logic        safe_s;
    logic        warn_s;
    logic        ack_s;

    ssei_sync #(
        .WIDTH (14)
    ) u_sync (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .async_in ({torque_off_input_a, torque_off_input_b, module_power_ok,
                    drive_power_ok, module_present, module_type_known,
                    module_voltage_fault, module_matches_design, module_change_accept,
                    module_supported, stage_modulating, drive_safe_status,
                    warning_mode, error_ack}),
        .sync_out (pins_s)
    );

    assign {in_a_s, in_b_s, mod_pwr_s, drv_pwr_s, present_s, known_s, vfault_s,
            match_s, accept_s, supp_s, pwm_s, safe_s, warn_s, ack_s} = pins_s;

    // ------------------------------------------------------------
    // Safe torque off state: both channels de-energised (0 V)
    // ------------------------------------------------------------
    logic sto_now;
    logic sto_prev_r;

    assign sto_now = ~in_a_s & ~in_b_s;

    // Status lamp and feedback contacts
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            lamp_colour              <= SSEI_LAMP_OFF;
            state_feedback_contact_1 <= 1'b0;
            state_feedback_contact_2 <= 1'b0;
            sto_active               <= 1'b0;
            sto_prev_r               <= 1'b0;
        end
        else
        begin
            sto_prev_r               <= sto_now;
            sto_active               <= sto_now;
            state_feedback_contact_1 <= sto_now;
            state_feedback_contact_2 <= sto_now;
            if (!mod_pwr_s || !drv_pwr_s)
                lamp_colour <= SSEI_LAMP_OFF;
            else if (sto_now)
                lamp_colour <= SSEI_LAMP_YELLOW;
            else
                lamp_colour <= SSEI_LAMP_GREEN;
        end
    end

    // ------------------------------------------------------------
    // Discrepancy timer between the two channels
    // ------------------------------------------------------------
    logic [CW-1:0] disc_cnt_r;
    logic          disc_run_r;
    logic          disc_expired;

    assign disc_expired = disc_run_r && (disc_cnt_r >= CW'(DISC_CYCLES - 1));

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            disc_cnt_r <= '0;
            disc_run_r <= 1'b0;
        end
        else if (in_a_s == in_b_s)
        begin
            disc_cnt_r <= '0;
            disc_run_r <= 1'b0;
        end
        else if (!disc_run_r)
        begin
            disc_run_r <= 1'b1;
            disc_cnt_r <= '0;
        end
        else if (!disc_expired)
        begin
            disc_cnt_r <= disc_cnt_r + CW'(1);
        end
    end

    // ------------------------------------------------------------
    // Error flags: 51-0 and 51-3 sticky until reset, 51-2 until accepted, 52-x until acknowledged (set wins over acknowledge)
    // bit0 51-0, bit1 51-2, bit2 51-3, bit3 52-1, bit4 52-2
    // ------------------------------------------------------------
    logic [4:0] cause;
    logic [4:0] err_r;
    logic [1:0] settle_r;

    // Synchroniser fill after reset: its zeros would look like an absent module
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            settle_r <= 2'h0;
        else
            settle_r <= {settle_r[0], 1'b1};
    end

    assign cause[0] = ~present_s | ~known_s | vfault_s;
    assign cause[1] = present_s & ~match_s & ~accept_s;
    assign cause[2] = present_s & known_s & ~supp_s;
    assign cause[3] = disc_expired;
    assign cause[4] = sto_now & ~sto_prev_r & pwm_s;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            err_r <= SSEI_ERR_RST;
        else if (settle_r[1])
        begin
            // Module errors cannot be acknowledged; 51-2 lifts on acceptance
            err_r[0] <= err_r[0] | cause[0];
            err_r[1] <= (err_r[1] & ~accept_s) | cause[1];
            err_r[2] <= err_r[2] | cause[2];
            err_r[3] <= (err_r[3] & ~ack_s) | cause[3];
            err_r[4] <= (err_r[4] & ~ack_s) | cause[4];
        end
    end

    assign error_active = err_r;

    // ------------------------------------------------------------
    // Display sequencer
    // ------------------------------------------------------------
    function automatic logic [11:0] code_of(input logic [4:0] e);
        if (e[0])      code_of = SSEI_ERR_51_0;
        else if (e[1]) code_of = SSEI_ERR_51_2;
        else if (e[2]) code_of = SSEI_ERR_51_3;
        else if (e[3]) code_of = SSEI_ERR_52_1;
        else           code_of = SSEI_ERR_52_2;
    endfunction

    logic [CW-1:0] sym_cnt_r;
    logic [2:0]    pos_r;
    logic [11:0]   code;

    assign code = code_of(err_r);

    // Step through the message positions while an error stands
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || err_r == '0)
        begin
            sym_cnt_r <= '0;
            pos_r     <= '0;
        end
        else if (sym_cnt_r >= CW'(SYM_CYCLES - 1))
        begin
            sym_cnt_r <= '0;
            pos_r     <= (pos_r == 3'(SSEI_MSG_LEN - 1)) ? 3'h0 : pos_r + 3'h1;
        end
        else
            sym_cnt_r <= sym_cnt_r + CW'(1);
    end

    // Symbol choice: errors first, then safe status, else normal display
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            display_symbol <= SSEI_CH_BLANK;
        else if (err_r != '0)
        begin
            case (pos_r)
                3'h0:    display_symbol <= warn_s ? SSEI_CH_HYPHEN : SSEI_CH_E;
                3'h1:    display_symbol <= {1'b0, code[11:8]};
                3'h2:    display_symbol <= {1'b0, code[7:4]};
                3'h3:    display_symbol <= {1'b0, code[3:0]};
                3'h4:    display_symbol <= warn_s ? SSEI_CH_HYPHEN : SSEI_CH_BLANK;
                default: display_symbol <= SSEI_CH_BLANK;
            endcase
        end
        else if (safe_s)
            display_symbol <= SSEI_CH_H;
        else
            display_symbol <= normal_symbol;
    end

endmodule

/* sim/ssei_top_assertions.sv */
// Concurrent checks on the ports of the status and error indicator
`timescale 1ns/1ps
module ssei_top_assertions
    import ssei_pkg::*;
#(
    parameter int DISC_CYCLES = SSEI_DISC_CYCLES
) (
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       torque_off_input_a,
    input wire logic       torque_off_input_b,
    input wire logic       module_power_ok,
    input wire logic       module_present,
    input wire logic       module_supported,
    input wire logic       stage_modulating,
    input wire logic [1:0] lamp_colour,
    input wire logic       state_feedback_contact_1,
    input wire logic       state_feedback_contact_2,
    input wire logic [4:0] error_active,
    input wire logic       sto_active
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [31:0] disc_cnt_r;

    // Cycles the two channels have disagreed
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || torque_off_input_a == torque_off_input_b)
            disc_cnt_r <= '0;
        else if (disc_cnt_r != '1)
            disc_cnt_r <= disc_cnt_r + 1;
    end

    sequence s_modulating;
        stage_modulating[*6];
    endsequence

    AST_LAMP_YELLOW: assert property (sto_active && lamp_colour != SSEI_LAMP_OFF |->
        lamp_colour == SSEI_LAMP_YELLOW) else $error("lamp not yellow in safe state");
    AST_LAMP_GREEN: assert property (!sto_active && lamp_colour != SSEI_LAMP_OFF |->
        lamp_colour == SSEI_LAMP_GREEN) else $error("lamp not green outside safe state");
    AST_LAMP_DARK: assert property (!module_power_ok[*4] |->
        lamp_colour == SSEI_LAMP_OFF) else $error("lamp lit without module voltage");
    AST_CONTACTS: assert property (state_feedback_contact_1 == sto_active &&
        state_feedback_contact_2 == sto_active) else $error("feedback contacts wrong");
    AST_DISC: assert property (disc_cnt_r == DISC_CYCLES + 4 |-> ##[0:4] error_active[3])
        else $error("discrepancy error missing");
    AST_STAGE: assert property (s_modulating ##0 $rose(sto_active) |->
        ##[0:3] error_active[4]) else $error("stage error missing");
    AST_ABSENT: assert property (!module_present[*4] |-> ##[0:2] error_active[0])
        else $error("absent module error missing");
    AST_UNSUP: assert property (!module_supported[*4] |-> ##[0:2] error_active[2])
        else $error("unsupported module error missing");
    AST_STICKY0: assert property (error_active[0] |=> error_active[0])
        else $error("module error dropped before reset");
    AST_STICKY2: assert property (error_active[2] |=> error_active[2])
        else $error("version error dropped before reset");
endmodule

bind ssei_top ssei_top_assertions #(.DISC_CYCLES(DISC_CYCLES)) u_ssei_top_assertions (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .torque_off_input_a(torque_off_input_a),
    .torque_off_input_b(torque_off_input_b), .module_power_ok(module_power_ok),
    .module_present(module_present), .module_supported(module_supported),
    .stage_modulating(stage_modulating), .lamp_colour(lamp_colour),
    .state_feedback_contact_1(state_feedback_contact_1),
    .state_feedback_contact_2(state_feedback_contact_2),
    .error_active(error_active), .sto_active(sto_active));

/* sim/ssei_safety_switch.sv */
// Safety switching device: drives both channels, channel b lagging by skew cycles
`timescale 1ns/1ps
module ssei_safety_switch (
    input  wire logic       clk_sys,
    input  wire logic       req_safe,
    input  wire logic [7:0] skew,
    output logic            ch_a,
    output logic            ch_b
);
    logic [7:0] lag_r = '0;

    // Both channels go low for the safe state, b after the set lag
    always_ff @(posedge clk_sys)
    begin
        ch_a <= !req_safe;
        if (ch_b == !req_safe)
            lag_r <= '0;
        else if (lag_r >= skew)
        begin
            ch_b  <= !req_safe;
            lag_r <= '0;
        end
        else
            lag_r <= lag_r + 8'h01;
    end
endmodule

/* sim/ssei_top_bench.sv */
// Self-checking bench for the status and error indicator
`timescale 1ns/1ps
module ssei_top_bench;
    import ssei_pkg::*;
    logic clk_sys = 0, sys_rst = 1, req = 1, a, b, mpw = 1, dpw = 1, pres = 1, known = 1;
    logic fault = 0, match = 1, acc = 0, sup = 1, stg = 0, safe = 0, warn = 0, ack = 0;
    logic [7:0] skew = '0;
    logic [4:0] nsym = 5'h07, disp, err;
    logic [1:0] lamp;
    logic c1, c2, sto, se, sh, s5;
    int n_fail = 0, checks_done = 0;

    always #20 clk_sys = !clk_sys;

    ssei_safety_switch u_ssei_safety_switch (.clk_sys(clk_sys), .req_safe(req), .skew(skew),
        .ch_a(a), .ch_b(b));
    ssei_top #(.DISC_CYCLES(8), .SYM_CYCLES(4)) u_ssei_top (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .torque_off_input_a(a), .torque_off_input_b(b),
        .module_power_ok(mpw), .drive_power_ok(dpw), .module_present(pres),
        .module_type_known(known), .module_voltage_fault(fault), .module_matches_design(match),
        .module_change_accept(acc), .module_supported(sup), .stage_modulating(stg),
        .drive_safe_status(safe), .warning_mode(warn), .error_ack(ack), .normal_symbol(nsym),
        .lamp_colour(lamp), .state_feedback_contact_1(c1), .state_feedback_contact_2(c2),
        .display_symbol(disp), .error_active(err), .sto_active(sto));

    task cyc(input int n); repeat (n) @(posedge clk_sys); #1; endtask
    task rst; sys_rst = 1; cyc(12); sys_rst = 0; cyc(1); endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
            n_fail++;
        end
    endtask
    task pulse_ack; ack = 1; cyc(4); ack = 0; cyc(4); endtask
    task scan;
        se = 0; sh = 0; s5 = 0;
        repeat (30)
        begin
            cyc(1);
            se |= (disp === SSEI_CH_E);
            sh |= (disp === SSEI_CH_HYPHEN);
            s5 |= (disp === 5'h05);
        end
    endtask

    task t_lamp;
        mpw = 0; cyc(5); chk(lamp, SSEI_LAMP_OFF); mpw = 1;
        req = 0; cyc(6); chk(lamp, SSEI_LAMP_GREEN); chk({c1, c2}, 2'b00);
        chk(sto, 1'b0);
        req = 1; cyc(6); chk(lamp, SSEI_LAMP_YELLOW); chk({c1, c2}, 2'b11);
        chk(sto, 1'b1);
        dpw = 0; cyc(5); chk(lamp, SSEI_LAMP_OFF); dpw = 1;
    endtask
    task t_disc;
        skew = 8'h02; req = 0; cyc(10); req = 1; cyc(20); chk(err[3], 0);
        skew = 8'h14; req = 0; cyc(30); chk(err[3], 1);
        pulse_ack; chk(err[3], 0); skew = '0;
    endtask
    task t_stage;
        stg = 1; cyc(8); req = 1; cyc(8); chk(err[4], 1);
        stg = 0; pulse_ack; chk(err[4], 0);
    endtask
    task t_module;
        for (int i = 0; i < 3; i++)
        begin
            pres = (i != 0); known = (i != 1); fault = (i == 2);
            cyc(5); chk(err[0], 1);
            pulse_ack; chk(err[0], 1); rst; cyc(5); chk(err[0], 1);
            pres = 1; known = 1; fault = 0; rst; cyc(5); chk(err[0], 0);
        end
        match = 0; cyc(5); chk(err[1], 1); match = 1; cyc(5); chk(err[1], 1);
        acc = 1; cyc(5); acc = 0; cyc(2); chk(err[1], 0);
        sup = 0; cyc(5); chk(err[2], 1); sup = 1; rst;
    endtask
    task t_display;
        cyc(5); chk(disp, nsym); safe = 1; cyc(5); chk(disp, SSEI_CH_H); safe = 0;
        pres = 0; cyc(5); scan; chk({se, s5}, 2'b11);
        warn = 1; cyc(25); scan; chk({se, sh, s5}, 3'b011);
        pres = 1; warn = 0; rst;
    endtask

    task finish_test;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Main sequence after the opening reset
    initial
    begin
        rst; t_lamp; t_disc; t_stage; t_module; t_display;
        finish_test;
    end

    // Watchdog well beyond the expected run
    initial
    begin
        #(40 * 4000);
        n_fail++;
        finish_test;
    end
endmodule
